// ---- logic/fpc_defs.svh ----
// Constants for the coprocessor opcode decoder.
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// ----------------------------------------
// Upper nibble of a one-byte opcode
// ----------------------------------------
`define FPC_N_PICKA 4'h0
`define FPC_N_PICKO 4'h1
`define FPC_N_LDACC 4'h2
`define FPC_N_LDOPD 4'h3
`define FPC_N_RDREG 4'h4
`define FPC_N_COPY 4'h5
`define FPC_N_FLOAT_SUM_OP 4'h6
`define FPC_N_FLOAT_QUOTIENT_OP 4'h9
`define FPC_N_IADD 4'hA
`define FPC_N_ISUB 4'hB
`define FPC_N_IMUL 4'hC
`define FPC_N_IDIV 4'hD
`define FPC_N_UNARY 4'hE
`define FPC_N_MISC 4'hF
// ----------------------------------------
// Lower nibble within the miscellaneous row
// ----------------------------------------
`define FPC_L_SYNC 4'h0
`define FPC_L_I2F 4'h1
`define FPC_L_F2I 4'h2
`define FPC_L_CMP 4'h3
`define FPC_L_SB 4'h4
`define FPC_L_UB 4'h5
`define FPC_L_SW 4'h6
`define FPC_L_UW 4'h7
`define FPC_L_TXT 4'h8
`define FPC_L_PARF 4'h9
`define FPC_L_FMTF 4'hA
`define FPC_L_PARI 4'hB
`define FPC_L_FMTI 4'hC
`define FPC_L_STAT 4'hD
`define FPC_L_PREFIX 4'hE
// ----------------------------------------
// Extended codes, replies and status bits
// ----------------------------------------
`define FPC_USER_LAST 8'h3F
`define FPC_IF_ACC 8'h80
`define FPC_IF_OPD 8'h81
`define FPC_IF_REL 8'h82
`define FPC_SYNC_ACK 8'h5C
`define FPC_TXT_LAST 4'hF
`define FPC_DIV0_Q 32'hFFFFFFFF
`define FPC_ST_ZERO 0
`define FPC_ST_NEG 1
`define FPC_ST_NAN 2
`define FPC_ST_INF 3
`define FPC_RL_EQ 0
`define FPC_RL_LT 1
`define FPC_RL_UN 2
`endif

// ---- logic/fpc_pkg.sv ----
// Types shared by the coprocessor opcode decoder.
package fpc_pkg;
  typedef enum logic [2:0] {ST_GET, ST_MEM, ST_ENG, ST_RESP, ST_HDR0, ST_HDR1} fpc_state_t;
  typedef enum logic [2:0] {PH_OP, PH_EXT, PH_ARG, PH_STR, PH_MASK} fpc_phase_t;
endpackage : fpc_pkg

// ---- logic/fpc_fstat.sv ----
// Float status and float relation bytes.
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_fstat (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // Status bytes
  output logic [7:0] sta,
  output logic [7:0] stb,
  output logic [7:0] rel
);
  function automatic logic [7:0] stat(input logic [31:0] x);
    logic [7:0] s;
    s = '0;
    s[`FPC_ST_ZERO] = (x[30:0] == 31'h0);
    s[`FPC_ST_NEG] = x[31];
    s[`FPC_ST_NAN] = (&x[30:23]) && (|x[22:0]);
    s[`FPC_ST_INF] = (&x[30:23]) && (x[22:0] == 23'h0);
    return s;
  endfunction : stat

  // Sign-magnitude mapped to an unsigned key so one compare orders floats.
  function automatic logic [31:0] key(input logic [31:0] x);
    return x[31] ? ~x : {1'b1, x[30:0]};
  endfunction : key

  assign sta = stat(a);
  assign stb = stat(b);

  always_comb begin
    rel = '0;
    if (sta[`FPC_ST_NAN] || stb[`FPC_ST_NAN]) begin
      rel[`FPC_RL_UN] = 1'b1;
    end else if ((sta[`FPC_ST_ZERO] && stb[`FPC_ST_ZERO]) || a == b) begin
      rel[`FPC_RL_EQ] = 1'b1;
    end else if (key(a) < key(b)) begin
      rel[`FPC_RL_LT] = 1'b1;
    end
  end
endmodule : fpc_fstat

// ---- logic/fpc_textbuf.sv ----
// Text buffer for string opcodes.
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_textbuf (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic clr,
  input wire logic app,
  input wire logic [7:0] app_byte,
  input wire logic load,
  input wire logic [127:0] load_data,
  // Contents
  output logic [127:0] flat
);
  logic [7:0] mem_q [16];
  logic [3:0] ptr_q;

  // The last slot is never appended, so a terminator remains unless a load fills all 16 slots.
  always_ff @(posedge mclk) begin
    if (sys_rst || clr) begin
      ptr_q <= '0;
    end else if (app && ptr_q != `FPC_TXT_LAST) begin
      ptr_q <= ptr_q + 4'd1;
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_ent
    always_ff @(posedge mclk) begin
      if (sys_rst || clr) begin
        mem_q[i] <= '0;
      end else if (load) begin
        mem_q[i] <= load_data[i*8 +: 8];
      end else if (app && ptr_q == 4'(i) && ptr_q != `FPC_TXT_LAST) begin
        mem_q[i] <= app_byte;
      end
    end
    assign flat[i*8 +: 8] = mem_q[i];
  end
endmodule : fpc_textbuf

// ---- logic/fpc_decoder.sv ----
// Opcode decoder and sequencer of the float and long integer coprocessor.
// Notes on behaviour
// - Nibbles 0,1 pick accumulator/operand; 2 loads accumulator.
// - Nibble 3 picks operand, loads four bytes.
// - Nibble 5 copies operand into accumulator.
// - Nibbles 6-9 float add, sub, mul, div.
// - Nibbles A-C integer add, sub, mul.
// - Nibble D divides; remainder to register 0.
// - E0-E7 root, logs, powers, trig in radians.
// - E8-ED floor, ceil, round, negate, abs, reciprocal.
// - EE/EF convert radians and degrees.
// - F1 copies accumulator to r0, int to float.
// - F2 copies accumulator to r0, float to int.
// - F3 replies one float relation byte.
// - F4/F5 byte to float in r0.
// - F6/F7 word to float in r0.
// - F8 returns text buffer, zero terminated.
// - F9/FB parse text into r0.
// - FA/FC render accumulator into text buffer.
// - FD replies accumulator float status byte.
// - FE is prefix; FF does nothing.
// - Prefixed 00-3F call user function.
// - Prefixed 80-82 conditionally run next code inside a user function.
// - Busy stays high through a user function.
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host byte stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic busy_q,
  // Host read-back
  input wire logic rsp_take,
  output logic rsp_valid_q,
  output logic [7:0] rsp_byte_q,
  // Math engine
  output logic eng_req_q,
  output logic [7:0] eng_op_q,
  output logic [31:0] eng_a_q,
  output logic [31:0] eng_b_q,
  output logic [127:0] eng_text_q,
  input wire logic eng_ack,
  input wire logic [31:0] eng_result,
  input wire logic [127:0] eng_text,
  // User function memory
  output logic [9:0] ufm_addr_q,
  input wire logic [7:0] ufm_rdata
);
  import fpc_pkg::*;

  logic [31:0] regs [16];
  fpc_state_t state_q, state_d, nxt;
  fpc_phase_t ph_q, d_ph;
  logic [3:0] acc_q, opd_q, tidx_q, tnx, dst_q, d_sel, d_wi, d_ed;
  logic [7:0] op_q, b, sta, stb, rel, cs, d_eop;
  logic [31:0] av, sv, aw, ext, sum, dif, quot, rem, d_wv, d_ea, d_eb, d_rv, rsp_sr_q, arg_q;
  logic [63:0] prod;
  logic [2:0] left_q, rsp_left_q, d_left, d_rc;
  logic [9:0] pc_q, end_q;
  logic [127:0] tflat;
  logic fn_q, fn_d, skip_q, rsp_txt_q, host_take, byte_ok, op_ok, last, fmt_op;
  logic d_acc_we, d_opd_we, d_wr, d_r0, d_eng, d_rsp, d_rtx, d_arg, d_call;
  logic d_clr, d_app, d_msk, d_fin;

  // ----------------------------------------
  // Byte source and operand values
  // ----------------------------------------
  assign host_take = cmd_valid & ~busy_q;
  assign byte_ok = host_take | (state_q == ST_MEM);
  assign b = fn_q ? ufm_rdata : cmd_byte;
  assign op_ok = byte_ok && ph_q == PH_OP && !skip_q;
  assign av = regs[acc_q];
  assign sv = regs[b[3:0]];
  assign aw = {arg_q[23:0], b};
  assign sum = av + sv;
  assign dif = av - sv;
  assign prod = av * sv;
  // A zero divisor cannot trap here, so it yields all ones and keeps the dividend.
  // The casts keep the divide signed; an unsigned mux branch would otherwise make it unsigned.
  assign quot = (sv == 32'h0) ? `FPC_DIV0_Q : 32'($signed(av) / $signed(sv));
  assign rem = (sv == 32'h0) ? av : 32'($signed(av) % $signed(sv));
  assign d_eop = (ph_q == PH_OP) ? b : op_q;
  assign cs = (op_q == `FPC_IF_ACC) ? sta : (op_q == `FPC_IF_OPD) ? stb : rel;
  assign fmt_op = eng_op_q[7:4] == `FPC_N_MISC
                  && (eng_op_q[3:0] == `FPC_L_FMTF || eng_op_q[3:0] == `FPC_L_FMTI);

  always_comb begin
    case (op_q[3:0])
      `FPC_L_SB: ext = {{24{aw[7]}}, aw[7:0]};
      `FPC_L_UB: ext = {24'h0, aw[7:0]};
      `FPC_L_SW: ext = {{16{aw[15]}}, aw[15:0]};
      default: ext = {16'h0, aw[15:0]};
    endcase
  end

  fpc_fstat u_fstat (
    .a(av),
    .b(regs[opd_q]),
    .sta(sta),
    .stb(stb),
    .rel(rel)
  );

  fpc_textbuf u_text (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(d_clr),
    .app(d_app),
    .app_byte(b),
    .load(state_q == ST_ENG && eng_ack && fmt_op),
    .load_data(eng_text),
    .flat(tflat)
  );

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  always_comb begin
    d_ph = ph_q;
    d_acc_we = 1'b0;
    d_opd_we = 1'b0;
    d_sel = b[3:0];
    d_wr = 1'b0;
    d_wi = acc_q;
    d_wv = sv;
    d_r0 = 1'b0;
    d_eng = 1'b0;
    d_ea = av;
    d_eb = sv;
    d_ed = acc_q;
    d_rsp = 1'b0;
    d_rtx = 1'b0;
    d_rv = '0;
    d_rc = 3'd1;
    d_arg = 1'b0;
    d_left = left_q;
    d_call = 1'b0;
    d_clr = 1'b0;
    d_app = 1'b0;
    d_msk = 1'b0;
    d_fin = 1'b0;
    if (byte_ok) begin
      case (ph_q)
        PH_OP: begin
          d_fin = 1'b1;
          case (b[7:4])
            `FPC_N_PICKA: d_acc_we = 1'b1;
            `FPC_N_PICKO: d_opd_we = 1'b1;
            `FPC_N_LDACC, `FPC_N_LDOPD: begin
              d_acc_we = (b[7:4] == `FPC_N_LDACC);
              d_opd_we = (b[7:4] == `FPC_N_LDOPD);
              d_ph = PH_ARG;
              d_left = 3'd4;
              d_fin = 1'b0;
            end
            `FPC_N_RDREG: begin
              d_rsp = 1'b1;
              d_rv = sv;
              d_rc = 3'd4;
            end
            `FPC_N_COPY: begin
              d_opd_we = 1'b1;
              d_wr = 1'b1;
            end
            `FPC_N_IADD, `FPC_N_ISUB, `FPC_N_IMUL, `FPC_N_IDIV: begin
              d_opd_we = 1'b1;
              d_wr = 1'b1;
              d_r0 = (b[7:4] == `FPC_N_IDIV);
              case (b[7:4])
                `FPC_N_IADD: d_wv = sum;
                `FPC_N_ISUB: d_wv = dif;
                `FPC_N_IMUL: d_wv = prod[31:0];
                default: d_wv = quot;
              endcase
            end
            `FPC_N_UNARY: d_eng = 1'b1;
            `FPC_N_MISC: begin
              case (b[3:0])
                `FPC_L_SYNC: begin
                  d_rsp = 1'b1;
                  d_rv = {`FPC_SYNC_ACK, 24'h0};
                end
                `FPC_L_I2F, `FPC_L_F2I: begin
                  d_wr = 1'b1;
                  d_wi = '0;
                  d_wv = av;
                  d_eng = 1'b1;
                  d_ed = '0;
                  d_opd_we = 1'b1;
                  d_sel = '0;
                end
                `FPC_L_CMP: begin
                  d_rsp = 1'b1;
                  d_rv = {rel, 24'h0};
                end
                `FPC_L_SB, `FPC_L_UB, `FPC_L_SW, `FPC_L_UW, `FPC_L_FMTF, `FPC_L_FMTI: begin
                  d_ph = PH_ARG;
                  d_left = (b[3:0] == `FPC_L_SW || b[3:0] == `FPC_L_UW) ? 3'd2 : 3'd1;
                  d_fin = 1'b0;
                end
                `FPC_L_TXT: begin
                  d_rsp = 1'b1;
                  d_rtx = 1'b1;
                end
                `FPC_L_PARF, `FPC_L_PARI: begin
                  d_clr = 1'b1;
                  d_ph = PH_STR;
                  d_fin = 1'b0;
                end
                `FPC_L_STAT: begin
                  d_rsp = 1'b1;
                  d_rv = {sta, 24'h0};
                end
                `FPC_L_PREFIX: begin
                  d_ph = PH_EXT;
                  d_fin = 1'b0;
                end
                default: d_fin = 1'b1;
              endcase
            end
            default: begin
              d_opd_we = 1'b1;
              d_eng = 1'b1;
            end
          endcase
        end
        PH_ARG: begin
          d_arg = 1'b1;
          d_left = left_q - 3'd1;
          if (left_q == 3'd1) begin
            d_ph = PH_OP;
            d_fin = 1'b1;
            if (op_q[7:4] != `FPC_N_MISC) begin
              d_wr = 1'b1;
              d_wi = op_q[3:0];
              d_wv = aw;
            end else if (op_q[3:0] == `FPC_L_FMTF || op_q[3:0] == `FPC_L_FMTI) begin
              d_eng = 1'b1;
              d_eb = {24'h0, b};
            end else begin
              d_wr = 1'b1;
              d_wi = '0;
              d_wv = ext;
              d_eng = 1'b1;
              d_ea = ext;
              d_ed = '0;
              d_opd_we = 1'b1;
              d_sel = '0;
            end
          end
        end
        PH_STR: begin
          if (b == 8'h00) begin
            d_eng = 1'b1;
            d_ea = '0;
            d_ed = '0;
            d_opd_we = 1'b1;
            d_sel = '0;
            d_ph = PH_OP;
            d_fin = 1'b1;
          end else begin
            d_app = 1'b1;
          end
        end
        PH_EXT: begin
          d_ph = PH_OP;
          if (b <= `FPC_USER_LAST) begin
            d_call = 1'b1;
            d_opd_we = 1'b1;
            d_sel = '0;
            d_fin = 1'b1;
          end else if (b == `FPC_IF_ACC || b == `FPC_IF_OPD || b == `FPC_IF_REL) begin
            d_ph = PH_MASK;
          end else begin
            d_fin = 1'b1;
          end
        end
        default: begin
          d_msk = 1'b1;
          d_fin = skip_q;
          d_ph = PH_OP;
        end
      endcase
      // A skipped instruction still consumes its bytes but changes nothing.
      if (skip_q) begin
        d_acc_we = 1'b0;
        d_opd_we = 1'b0;
        d_wr = 1'b0;
        d_r0 = 1'b0;
        d_eng = 1'b0;
        d_rsp = 1'b0;
        d_call = 1'b0;
        d_clr = 1'b0;
        d_app = 1'b0;
      end
    end
  end

  assign nxt = d_call ? ST_HDR0 : d_eng ? ST_ENG : d_rsp ? ST_RESP : ST_GET;
  assign last = rsp_valid_q && rsp_take && (rsp_txt_q ? rsp_byte_q == 8'h00 : rsp_left_q == 3'd0);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    fn_d = fn_q;
    case (state_q)
      ST_GET: begin
        if (fn_q) begin
          if (pc_q == end_q) begin
            fn_d = 1'b0;
          end else begin
            state_d = ST_MEM;
          end
        end else if (host_take) begin
          state_d = nxt;
        end
      end
      ST_MEM: state_d = nxt;
      ST_ENG: state_d = eng_ack ? ST_GET : ST_ENG;
      ST_RESP: state_d = last ? ST_GET : ST_RESP;
      ST_HDR0: state_d = ST_HDR1;
      ST_HDR1: begin
        state_d = ST_GET;
        fn_d = 1'b1;
      end
      default: state_d = ST_GET;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_GET;
      fn_q <= 1'b0;
      busy_q <= 1'b1;
      ph_q <= PH_OP;
    end else begin
      state_q <= state_d;
      fn_q <= fn_d;
      busy_q <= (state_d != ST_GET) || fn_d;
      ph_q <= d_ph;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_q <= '0;
      opd_q <= '0;
    end else begin
      if (d_acc_we) acc_q <= d_sel;
      if (d_opd_we) opd_q <= d_sel;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      op_q <= '0;
      arg_q <= '0;
      left_q <= '0;
      skip_q <= 1'b0;
    end else begin
      if (byte_ok && (ph_q == PH_OP || ph_q == PH_EXT)) op_q <= b;
      if (d_arg) arg_q <= aw;
      left_q <= d_left;
      // Conditions only act inside a stored function.
      if (d_msk && !skip_q) skip_q <= fn_q && !(|(cs & b));
      else if (d_fin) skip_q <= 1'b0;
    end
  end

  // Register file holds data only, so it is left out of reset.
  always_ff @(posedge mclk) begin
    if (d_wr) regs[d_wi] <= d_wv;
    if (d_r0) regs[0] <= rem;
    if (state_q == ST_ENG && eng_ack && !fmt_op) regs[dst_q] <= eng_result;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      eng_req_q <= 1'b0;
      eng_op_q <= '0;
      eng_a_q <= '0;
      eng_b_q <= '0;
      eng_text_q <= '0;
      dst_q <= '0;
    end else if (d_eng) begin
      eng_req_q <= 1'b1;
      eng_op_q <= d_eop;
      eng_a_q <= d_ea;
      eng_b_q <= d_eb;
      eng_text_q <= tflat;
      dst_q <= d_ed;
    end else if (eng_ack) begin
      eng_req_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ufm_addr_q <= '0;
      pc_q <= '0;
      end_q <= '0;
    end else begin
      if (d_call) ufm_addr_q <= {3'b000, b[5:0], 1'b0};
      else if (state_q == ST_HDR0) ufm_addr_q <= ufm_addr_q + 10'd1;
      else if (state_q == ST_GET && state_d == ST_MEM) ufm_addr_q <= pc_q;
      if (state_q == ST_HDR0) pc_q <= {ufm_rdata, 2'b00};
      else if (state_q == ST_MEM) pc_q <= pc_q + 10'd1;
      if (state_q == ST_HDR1) end_q <= pc_q + {2'b00, ufm_rdata};
    end
  end

  // ----------------------------------------
  // Read-back to the host
  // ----------------------------------------
  assign tnx = tidx_q + 4'd1;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_byte_q <= '0;
      rsp_sr_q <= '0;
      rsp_left_q <= '0;
      rsp_txt_q <= 1'b0;
      tidx_q <= '0;
    end else if (d_rsp) begin
      rsp_valid_q <= 1'b1;
      rsp_txt_q <= d_rtx;
      tidx_q <= '0;
      rsp_byte_q <= d_rtx ? tflat[7:0] : d_rv[31:24];
      rsp_sr_q <= {d_rv[23:0], 8'h00};
      rsp_left_q <= d_rc - 3'd1;
    end else if (last) begin
      rsp_valid_q <= 1'b0;
    end else if (rsp_valid_q && rsp_take) begin
      tidx_q <= tnx;
      // The final slot is forced to the terminator.
      rsp_byte_q <= !rsp_txt_q ? rsp_sr_q[31:24] :
                    (tnx == `FPC_TXT_LAST) ? 8'h00 : tflat[{tnx, 3'b000} +: 8];
      rsp_sr_q <= {rsp_sr_q[23:0], 8'h00};
      rsp_left_q <= rsp_left_q - 3'd1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_call;
    byte_ok && ph_q == PH_EXT && !skip_q && b <= `FPC_USER_LAST;
  endsequence

  a_busy_func: assert property (fn_q |-> busy_q)
    else $error("busy low inside user function");
  a_pick_acc: assert property (op_ok && b[7:4] == `FPC_N_PICKA |=> acc_q == $past(b[3:0]))
    else $error("accumulator not picked");
  a_load_opd: assert property (op_ok && b[7:4] == `FPC_N_LDOPD |=> opd_q == $past(b[3:0])
    && ph_q == PH_ARG && left_q == 3'd4)
    else $error("operand load not started");
  a_copy_reg: assert property (op_ok && b[7:4] == `FPC_N_COPY |=> regs[acc_q] == $past(sv))
    else $error("copy into accumulator failed");
  a_float_eng: assert property (op_ok && b[7:4] >= `FPC_N_FLOAT_SUM_OP && b[7:4] <= `FPC_N_FLOAT_QUOTIENT_OP
    |=> eng_req_q && eng_op_q == $past(b) && state_q == ST_ENG)
    else $error("float op not issued");
  a_int_sum: assert property (op_ok && b[7:4] == `FPC_N_IADD |=> regs[acc_q] == $past(sum))
    else $error("integer sum wrong");
  a_rem_r0: assert property (op_ok && b[7:4] == `FPC_N_IDIV |=> regs[0] == $past(rem))
    else $error("remainder not in register 0");
  a_rel_reply: assert property (op_ok && b == {`FPC_N_MISC, `FPC_L_CMP}
    |=> rsp_valid_q && rsp_byte_q == $past(rel))
    else $error("relation byte wrong");
  a_call_enter: assert property (s_call |-> ##3 (fn_q && opd_q == 4'h0 && busy_q))
    else $error("user function not entered");
  a_msb_first: assert property (rsp_valid_q && rsp_take && !rsp_txt_q && rsp_left_q != 3'd0
    |=> rsp_byte_q == $past(rsp_sr_q[31:24]))
    else $error("reply byte order wrong");
endmodule : fpc_decoder

// ---- testbench/fpc_eng_model.sv ----
// Math engine and user function memory model facing the decoder.
`timescale 1ns/1ps
module fpc_eng_model #(parameter int SLOW = 5) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Engine port
  input wire logic eng_req_q,
  input wire logic [7:0] eng_op_q,
  input wire logic [31:0] eng_a_q,
  input wire logic [31:0] eng_b_q,
  output logic eng_ack,
  output logic [31:0] eng_result,
  output logic [127:0] eng_text,
  // Function memory
  input wire logic [9:0] ufm_addr_q,
  output logic [7:0] ufm_rdata
);
  logic [7:0] cnt_q;
  logic slow_q;
  logic [31:0] res;
  // Only the two-operand float rows use the operand; other codes depend on the first value.
  assign res = eng_a_q + 32'(eng_op_q) + (eng_op_q < 8'hA0 ? eng_b_q : 32'h0);
  // Off the acknowledge cycle the bus carries garbage, so a late sample is caught.
  assign eng_result = eng_ack ? res : ~res;
  assign eng_text = {16{8'h30}};
  // Answers alternate between prompt and slow.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= 8'h0;
      eng_ack <= 1'b0;
      slow_q <= 1'b0;
    end else if (eng_req_q && !eng_ack) begin
      if (cnt_q >= (slow_q ? 8'(SLOW) : 8'h0)) begin
        eng_ack <= 1'b1;
        cnt_q <= 8'h0;
        slow_q <= !slow_q;
      end else begin
        cnt_q <= cnt_q + 8'h1;
      end
    end else begin
      eng_ack <= 1'b0;
    end
  end
  // Function 0 starts at 0x40 and holds two bytes; erased bytes read 0xFF.
  // Function 1 starts at 0x44: one condition that holds and one that does not.
  always_comb begin
    case (ufm_addr_q)
      10'h000: ufm_rdata = 8'h10;
      10'h001: ufm_rdata = 8'h02;
      10'h040: ufm_rdata = 8'h51;
      10'h041: ufm_rdata = 8'h61;
      10'h002: ufm_rdata = 8'h11;
      10'h003: ufm_rdata = 8'h08;
      10'h044: ufm_rdata = 8'hFE;
      10'h045: ufm_rdata = 8'h81;
      10'h046: ufm_rdata = 8'h01;
      10'h047: ufm_rdata = 8'hE0;
      10'h048: ufm_rdata = 8'hFE;
      10'h049: ufm_rdata = 8'h80;
      10'h04A: ufm_rdata = 8'h01;
      10'h04B: ufm_rdata = 8'h51;
      default: ufm_rdata = 8'hFF;
    endcase
  end
endmodule : fpc_eng_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the coprocessor opcode decoder.
`timescale 1ns/1ps
module testbench;
  logic mclk, sys_rst, cmd_valid, rsp_take, eng_ack, busy_q, rsp_valid_q, eng_req_q, eng_seen;
  logic [7:0] cmd_byte, rsp_byte_q, eng_op_q, ufm_rdata;
  logic [31:0] eng_a_q, eng_b_q, eng_result, x_q, v1, v2, acc;
  logic [127:0] eng_text_q, eng_text;
  logic [9:0] ufm_addr_q;
  logic [7:0] rsp_exp[$];
  logic [39:0] eng_exp[$];
  int errors, n_compared, i;
  fpc_decoder fpc_decoder_inst (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .busy_q(busy_q), .rsp_take(rsp_take), .rsp_valid_q(rsp_valid_q),
    .rsp_byte_q(rsp_byte_q), .eng_req_q(eng_req_q), .eng_op_q(eng_op_q), .eng_a_q(eng_a_q),
    .eng_b_q(eng_b_q), .eng_text_q(eng_text_q), .eng_ack(eng_ack), .eng_result(eng_result),
    .eng_text(eng_text), .ufm_addr_q(ufm_addr_q), .ufm_rdata(ufm_rdata));
  fpc_eng_model fpc_eng_model_inst (.mclk(mclk), .sys_rst(sys_rst), .eng_req_q(eng_req_q),
    .eng_op_q(eng_op_q), .eng_a_q(eng_a_q), .eng_b_q(eng_b_q), .eng_ack(eng_ack),
    .eng_result(eng_result), .eng_text(eng_text), .ufm_addr_q(ufm_addr_q),
    .ufm_rdata(ufm_rdata));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----
  // Tasks
  // ----
  function automatic logic [31:0] rnd();
    x_q ^= x_q << 13;
    x_q ^= x_q >> 17;
    x_q ^= x_q << 5;
    return x_q;
  endfunction : rnd
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp40(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp40
  // The byte is held until an edge that sees the decoder ready.
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    do begin
      @(posedge mclk);
      n++;
    end while (busy_q !== 1'b0 && n < 2000);
    if (busy_q !== 1'b0) errors++;
  endtask : send
  task automatic send32(input logic [31:0] v);
    for (int k = 3; k >= 0; k--) send(v[8*k +: 8]);
  endtask : send32
  task automatic rd(input logic [3:0] r, input logic [31:0] v);
    for (int k = 3; k >= 0; k--) rsp_exp.push_back(v[8*k +: 8]);
    send({4'h4, r});
  endtask : rd
  task automatic lda(input logic [31:0] v);
    send(8'h22);
    send32(v);
    acc = v;
  endtask : lda
  task automatic end_sim();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // ----
  // Watcher
  // ----
  always @(posedge mclk) begin
    if (rsp_valid_q === 1'b1 && !rsp_take)
      cmp8(rsp_byte_q, rsp_exp.size() ? rsp_exp.pop_front() : ~rsp_byte_q);
    rsp_take <= (rsp_valid_q === 1'b1 && !rsp_take);
    if (eng_req_q === 1'b1 && !eng_seen)
      cmp40({eng_op_q, eng_a_q}, eng_exp.size() ? eng_exp.pop_front() : ~{eng_op_q, eng_a_q});
    eng_seen <= (eng_req_q === 1'b1);
  end
  initial begin
    #2000000;
    errors++;
    end_sim();
  end
  // ----
  // Tests
  // ----
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    errors = 0;
    n_compared = 0;
    x_q = 32'd17524;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    v1 = rnd() | 32'h1;
    v2 = rnd();
    send(8'h31);
    send32(v1);
    lda(v2);
    rd(4'h1, v1);
    rd(4'h2, v2);
    $display("loads done");
    for (i = 10; i < 14; i++) begin
      lda(v2);
      send({i[3:0], 4'h1});
      case (i)
        10: acc = v2 + v1;
        11: acc = v2 - v1;
        12: acc = v2 * v1;
        default: acc = $signed(v2) / $signed(v1);
      endcase
      rd(4'h2, acc);
    end
    rd(4'h0, $signed(v2) % $signed(v1));
    $display("integer done");
    for (i = 6; i < 10; i++) begin
      lda(v2);
      eng_exp.push_back({i[3:0], 4'h1, v2});
      send({i[3:0], 4'h1});
      acc = v2 + v1 + 32'(i * 16 + 1);
      rd(4'h2, acc);
    end
    for (i = 8'hE0; i <= 8'hEF; i++) begin
      eng_exp.push_back({i[7:0], acc});
      send(i[7:0]);
      acc = acc + 32'(i);
    end
    rd(4'h2, acc);
    send(8'h51);
    rd(4'h2, v1);
    $display("float done");
    rsp_exp.push_back(8'h5C);
    send(8'hF0);
    send(8'hFF);
    for (i = 1; i < 8; i++) begin
      if (i == 3) continue;
      case (i)
        1, 2: v2 = v1;
        4: v2 = 32'hFFFFFF80;
        5: v2 = 32'h80;
        6: v2 = 32'hFFFF8001;
        default: v2 = 32'h8001;
      endcase
      eng_exp.push_back({4'hF, i[3:0], v2});
      send({4'hF, i[3:0]});
      if (i > 3) send(8'h80);
      if (i > 5) send(8'h01);
      rd(4'h0, v2 + 32'hF0 + 32'(i));
    end
    lda(32'h80000000);
    send(8'h30);
    send32(32'h0);
    rsp_exp.push_back(8'h01);
    send(8'hF3);
    rsp_exp.push_back(8'h03);
    send(8'hFD);
    $display("conversion done");
    send(8'h31);
    send32(v1);
    eng_exp.push_back({8'h61, v1});
    send(8'hFE);
    send(8'h00);
    rd(4'h2, v1 + v1 + 32'h61);
    eng_exp.push_back({8'hFA, v1 + v1 + 32'h61});
    send(8'hFA);
    send(8'h00);
    for (i = 0; i < 15; i++) rsp_exp.push_back(8'h30);
    rsp_exp.push_back(8'h00);
    send(8'hF8);
    acc = v1 + v1 + 32'h61;
    eng_exp.push_back({8'hE0, acc});
    send(8'hFE);
    send(8'h01);
    rd(4'h2, acc + 32'hE0);
    send(8'h00);
    rsp_exp.push_back(8'h01);
    send(8'hFD);
    eng_exp.push_back({8'hF9, 32'h0});
    send(8'hF9);
    send(8'h31);
    send(8'h32);
    send(8'h00);
    rd(4'h0, 32'hF9);
    cmp40(eng_text_q[39:0], 40'h3231);
    send(8'hFF);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge mclk);
    cmp8(8'(rsp_exp.size() + eng_exp.size()), 8'h00);
    $display("function and text done");
    end_sim();
  end
endmodule : testbench
